//--- rtl/pct_pkg.sv
// package: register map, field positions, timing constants and carriers for the periodic timer
package pct_pkg;

    // register offsets; printed offsets 0x0B..0x0F are not multiples of four, so they are indices
    localparam logic [3:0] PCT_IDX_PRESET_LO = 4'hB;
    localparam logic [3:0] PCT_IDX_PRESET_HI = 4'hC;
    localparam logic [3:0] PCT_IDX_EXT_CTRL  = 4'hD;
    localparam logic [3:0] PCT_IDX_FLAGS     = 4'hE;
    localparam logic [3:0] PCT_IDX_IRQ_CTRL  = 4'hF;
    localparam int         PCT_ADDR_W        = 6;

    // extension_control fields
    localparam int PCT_EXT_RUN_BIT  = 4;
    localparam int PCT_EXT_SEL_LSB  = 0;
    // event_flags fields
    localparam int PCT_FLG_TEF_BIT  = 4;
    // interrupt_control fields
    localparam int PCT_CTL_TIE_BIT  = 4;
    localparam int PCT_CTL_PAUSE_BIT = 2;
    localparam int PCT_CTL_HALT_BIT = 1;

    // reset values
    localparam logic [7:0]  PCT_EXT_RST    = 8'h00;
    localparam logic [7:0]  PCT_FLG_RST    = 8'h00;
    localparam logic [7:0]  PCT_CTL_RST    = 8'h00;
    localparam logic [15:0] PCT_PRESET_RST = 16'h0000;

    // source select codes
    localparam logic [2:0] PCT_SEL_4096 = 3'h0;
    localparam logic [2:0] PCT_SEL_64   = 3'h1;
    localparam logic [2:0] PCT_SEL_1HZ  = 3'h2;
    localparam logic [2:0] PCT_SEL_MIN  = 3'h3;
    localparam logic [2:0] PCT_SEL_HOUR = 3'h4;

    // timing: system clock and divider chain base
    localparam int PCT_CLK_HZ       = 100_000_000;
    localparam int PCT_XTAL_HZ      = 32768;
    // xtal tick period in system clocks (rounded down, so slightly shorter than the exact period)
    localparam int PCT_XTAL_CYC     = PCT_CLK_HZ / PCT_XTAL_HZ;
    // release times in xtal ticks, rounded to nearest: 122 us = 4 ticks, 7.813 ms = 256 ticks
    localparam int PCT_REL_FAST_US  = 122;
    localparam int PCT_REL_SLOW_US  = 7813;
    localparam int PCT_REL_FAST_TK  = (PCT_REL_FAST_US * PCT_XTAL_HZ + 500_000) / 1_000_000;
    localparam int PCT_REL_SLOW_TK  = (PCT_REL_SLOW_US * PCT_XTAL_HZ + 500_000) / 1_000_000;

    // avalon-mm slave request carrier
    typedef struct packed {
        logic [PCT_ADDR_W-1:0] address;
        logic                  read;
        logic                  write;
        logic [31:0]           writedata;
        logic [3:0]            byteenable;
    } pct_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } pct_av_rsp_t;

endpackage : pct_pkg

//--- rtl/pct_tick_gen.sv
// divider chain: produces one-cycle carries at 32768, 4096, 64, 1 Hz, per minute and per hour
`timescale 1ns/1ps
module pct_tick_gen
    import pct_pkg::*;
#(
    parameter int XTAL_CYC = PCT_XTAL_CYC,
    parameter int SEC_PER_MIN = 60,
    parameter int MIN_PER_HOUR = 60
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic halt_i,
    output logic      xtal_tick_o,
    output logic      tick_4096_o,
    output logic      tick_64_o,
    output logic      tick_1hz_o,
    output logic      tick_min_o,
    output logic      tick_hour_o
);

    typedef struct packed {
        logic [15:0] pre;
        logic [14:0] div;
        logic [5:0]  sec;
        logic [5:0]  min;
        logic [5:0]  ticks;
    } pct_tg_state_t;

    pct_tg_state_t st_r;
    pct_tg_state_t st_nxt;

    // the sub-4096 stages and time counters stop under halt; 4096 Hz keeps running
    always_comb begin
        logic xt;
        logic c4096;
        logic c64;
        logic c1;
        logic cm;
        logic ch;
        st_nxt = st_r;
        xt     = (st_r.pre == 16'(XTAL_CYC - 1));
        st_nxt.pre = xt ? 16'h0000 : st_r.pre + 16'h0001;
        c4096 = xt && (st_r.div[2:0] == 3'h7);
        c64   = c4096 && (st_r.div[8:3] == 6'h3F) && !halt_i;
        c1    = c64 && (st_r.div[14:9] == 6'h3F);
        cm    = c1 && (st_r.sec == 6'(SEC_PER_MIN - 1));
        ch    = cm && (st_r.min == 6'(MIN_PER_HOUR - 1));
        if (xt) begin
            st_nxt.div[2:0] = st_r.div[2:0] + 3'h1;
        end
        if (c4096 && !halt_i) begin
            st_nxt.div[14:3] = st_r.div[14:3] + 12'h001;
        end
        if (c1) begin
            st_nxt.sec = cm ? 6'h00 : st_r.sec + 6'h01;
        end
        if (cm) begin
            st_nxt.min = ch ? 6'h00 : st_r.min + 6'h01;
        end
        st_nxt.ticks = {ch, cm, c1, c64, c4096, xt};
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // carries are registered so each output comes from a flip-flop
    assign xtal_tick_o = st_r.ticks[0];
    assign tick_4096_o = st_r.ticks[1];
    assign tick_64_o   = st_r.ticks[2];
    assign tick_1hz_o  = st_r.ticks[3];
    assign tick_min_o  = st_r.ticks[4];
    assign tick_hour_o = st_r.ticks[5];

endmodule : pct_tick_gen

//--- rtl/pct_timer.sv
// periodic countdown timer with avalon-mm register slave and open-drain interrupt pin
//
// Summary of operation
// - periodic event from one 4096 Hz tick to 65535 hours
// - timer drives interrupt low, then releases it itself
// - slow sources release interrupt after 7.813 ms
// - 16-bit preset split over offsets 0B and 0C
// - counter reads preset when stopped, live count when running
// - live count not frozen; host reads twice
// - select codes pick 4096, 64, 1 Hz, minute, hour
// - release after 122 us at 4096 Hz, else 7.813 ms
// - clock halt stops all sources except 4096 Hz
// - first step aligns to next source carry
// - stopping timer keeps a low interrupt low
// - run rising edge restarts from stored preset
// - event sets flag, held until host clears it
// - writing zero clears flag, pin unaffected; one ignored
// - enabled events drive interrupt pin low
// - disabled events silent; clearing enable releases pin
// - other sources may hold the shared pin low
// - pause holds count, resume continues, pin unchanged
// - short pause need not delay next step
// - unused timer makes counter registers plain storage
// - one to zero raises event, reloads, repeats
// - counting starts at completion of run-setting write
`timescale 1ns/1ps
module pct_timer
    import pct_pkg::*;
#(
    parameter int XTAL_CYC     = PCT_XTAL_CYC,
    parameter int SEC_PER_MIN  = 60,
    parameter int MIN_PER_HOUR = 60
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire logic [PCT_ADDR_W-1:0] avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [31:0]           avs_readdata_o,
    output logic                       avs_waitrequest_o,
    input  wire logic                  irq_share_n_i,
    output logic                       irq_n_o,
    output logic                       irq_n_oe_o,
    output logic                       timer_event_o
);

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK  = 3'b010,
        BUS_DONE = 3'b100
    } pct_bus_t;

    typedef struct packed {
        logic [1:0]  share_sync;
        pct_bus_t    bus;
        logic [31:0] rdata;
        logic        wait_n;
        logic [15:0] preset;
        logic [7:0]  ext_ctrl;
        logic [7:0]  flags;
        logic [7:0]  irq_ctrl;
        logic [15:0] count;
        logic        running;
        logic        pin_low;
        logic [8:0]  rel_cnt;
        logic        evt;
        logic        wreq;
        logic        pin_oe;
    } pct_state_t;

    pct_state_t st_r;
    pct_state_t st_nxt;

    logic [1:0] rst_sync_r;
    logic rst_n_sync;
    logic xtal_tick;
    logic tick_4096;
    logic tick_64;
    logic tick_1hz;
    logic tick_min;
    logic tick_hour;

    assign rst_n_sync = rst_sync_r[1];

    // shared divider chain; the clock-halt bit freezes everything slower than 4096 Hz
    pct_tick_gen #(
        .XTAL_CYC     (XTAL_CYC),
        .SEC_PER_MIN  (SEC_PER_MIN),
        .MIN_PER_HOUR (MIN_PER_HOUR)
    ) u_tick_gen (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_sync),
        .halt_i      (st_r.irq_ctrl[PCT_CTL_HALT_BIT]),
        .xtal_tick_o (xtal_tick),
        .tick_4096_o (tick_4096),
        .tick_64_o   (tick_64),
        .tick_1hz_o  (tick_1hz),
        .tick_min_o  (tick_min),
        .tick_hour_o (tick_hour)
    );

    // next-state logic: bus slave, registers, countdown and pin release
    always_comb begin
        logic       sel_tick;
        logic       wr_hit;
        logic       rd_hit;
        logic [3:0] idx;
        logic [7:0] rbyte;
        logic [2:0] src;
        logic       run_new;
        logic       event_now;
        logic       flag_clr;
        logic       tie_clr;
        logic [8:0] rel_len;

        st_nxt           = st_r;
        sel_tick         = 1'b0;
        rel_len          = 9'h000;
        st_nxt.share_sync = {st_r.share_sync[0], irq_share_n_i};
        st_nxt.evt       = 1'b0;
        src      = st_r.ext_ctrl[PCT_EXT_SEL_LSB +: 3];
        idx      = avs_address_i[5:2];
        wr_hit   = 1'b0;
        rd_hit   = 1'b0;
        rbyte    = 8'h00;
        run_new  = st_r.ext_ctrl[PCT_EXT_RUN_BIT];
        flag_clr = 1'b0;
        tie_clr  = 1'b0;
        event_now = 1'b0;

        // source selection from the divider carries
        unique case (src)
            PCT_SEL_4096: sel_tick = tick_4096;
            PCT_SEL_64:   sel_tick = tick_64;
            PCT_SEL_1HZ:  sel_tick = tick_1hz;
            PCT_SEL_MIN:  sel_tick = tick_min;
            PCT_SEL_HOUR: sel_tick = tick_hour;
            default:      sel_tick = 1'b0;
        endcase

        // avalon slave: one wait cycle, then answer in BUS_ACK, recover in BUS_DONE
        st_nxt.wait_n = 1'b0;
        unique case (st_r.bus)
            BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    st_nxt.bus = BUS_ACK;
                    st_nxt.wait_n = 1'b1;
                    // live count read without freezing: host must double-read
                    unique case (idx)
                        PCT_IDX_PRESET_LO: rbyte = st_r.running ? st_r.count[7:0]
                                                                : st_r.preset[7:0];
                        PCT_IDX_PRESET_HI: rbyte = st_r.running ? st_r.count[15:8]
                                                                : st_r.preset[15:8];
                        PCT_IDX_EXT_CTRL:  rbyte = st_r.ext_ctrl;
                        PCT_IDX_FLAGS:     rbyte = st_r.flags;
                        PCT_IDX_IRQ_CTRL:  rbyte = st_r.irq_ctrl;
                        default:           rbyte = 8'h00;
                    endcase
                    rd_hit = avs_read_i;
                    st_nxt.rdata = rd_hit ? {24'h000000, rbyte} : 32'h00000000;
                end
            end
            BUS_ACK: begin
                st_nxt.bus = BUS_DONE;
                wr_hit = avs_write_i && avs_byteenable_i[0];
            end
            BUS_DONE: begin
                st_nxt.bus = BUS_IDLE;
            end
            default: begin
                st_nxt.bus = BUS_IDLE;
            end
        endcase

        // register writes take effect at the edge that completes the transfer
        if (wr_hit) begin
            unique case (idx)
                PCT_IDX_PRESET_LO: st_nxt.preset[7:0]  = avs_writedata_i[7:0];
                PCT_IDX_PRESET_HI: st_nxt.preset[15:8] = avs_writedata_i[7:0];
                PCT_IDX_EXT_CTRL: begin
                    st_nxt.ext_ctrl = avs_writedata_i[7:0];
                    run_new = avs_writedata_i[PCT_EXT_RUN_BIT];
                end
                PCT_IDX_FLAGS: begin
                    // flag bits are write-zero-to-clear, ones ignored
                    flag_clr = !avs_writedata_i[PCT_FLG_TEF_BIT];
                end
                PCT_IDX_IRQ_CTRL: begin
                    st_nxt.irq_ctrl = avs_writedata_i[7:0] & 8'h3E;
                    tie_clr = !avs_writedata_i[PCT_CTL_TIE_BIT];
                end
                default: begin
                end
            endcase
        end

        // run control: a rising run bit reloads the preset and starts at this edge
        if (run_new && !st_r.running) begin
            st_nxt.count = st_r.preset;
            if (wr_hit && idx == PCT_IDX_PRESET_LO) begin
                st_nxt.count[7:0] = avs_writedata_i[7:0];
            end
        end
        st_nxt.running = run_new;

        // countdown; pause only masks carries, so a short pause costs no step
        if (st_r.running && run_new && sel_tick
            && !st_r.irq_ctrl[PCT_CTL_PAUSE_BIT] && st_r.preset != 16'h0000) begin
            // first step lands on the next carry, later ones a full tick apart
            if (st_r.count <= 16'h0001) begin
                event_now = 1'b1;
                st_nxt.count = st_r.preset;
            end else begin
                st_nxt.count = st_r.count - 16'h0001;
            end
        end

        // event flag: set wins over a simultaneous host clear
        if (flag_clr) begin
            st_nxt.flags[PCT_FLG_TEF_BIT] = 1'b0;
        end
        if (event_now) begin
            st_nxt.flags[PCT_FLG_TEF_BIT] = 1'b1;
            st_nxt.evt = 1'b1;
        end

        // release length depends on source
        rel_len = (src == PCT_SEL_4096) ? 9'(PCT_REL_FAST_TK) : 9'(PCT_REL_SLOW_TK);

        // pin: assert on enabled event, self-release after the release time
        if (st_r.pin_low && xtal_tick) begin
            if (st_r.rel_cnt <= 9'h001) begin
                st_nxt.pin_low = 1'b0;
                st_nxt.rel_cnt = 9'h000;
            end else begin
                st_nxt.rel_cnt = st_r.rel_cnt - 9'h001;
            end
        end
        if (tie_clr) begin
            st_nxt.pin_low = 1'b0;
            st_nxt.rel_cnt = 9'h000;
        end
        if (event_now && st_r.irq_ctrl[PCT_CTL_TIE_BIT] && !tie_clr) begin
            st_nxt.pin_low = 1'b1;
            st_nxt.rel_cnt = rel_len;
        end

        // pin polarity worked out ahead so no gate follows the output flip-flops
        st_nxt.wreq   = !st_nxt.wait_n;
        st_nxt.pin_oe = !st_nxt.pin_low;
    end

    // reset synchroniser runs alone on the raw reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // remaining state on the synchronised reset
    always_ff @(posedge clock_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_r.share_sync <= 2'h3;
            st_r.bus        <= BUS_IDLE;
            st_r.rdata      <= 32'h00000000;
            st_r.wait_n     <= 1'b0;
            st_r.preset     <= PCT_PRESET_RST;
            st_r.ext_ctrl   <= PCT_EXT_RST;
            st_r.flags      <= PCT_FLG_RST;
            st_r.irq_ctrl   <= PCT_CTL_RST;
            st_r.count      <= PCT_PRESET_RST;
            st_r.running    <= 1'b0;
            st_r.pin_low    <= 1'b0;
            st_r.rel_cnt    <= 9'h000;
            st_r.evt        <= 1'b0;
            st_r.wreq       <= 1'b1;
            st_r.pin_oe     <= 1'b1;
        end else begin
            st_r.share_sync <= st_nxt.share_sync;
            st_r.bus        <= st_nxt.bus;
            st_r.rdata      <= st_nxt.rdata;
            st_r.wait_n     <= st_nxt.wait_n;
            st_r.preset     <= st_nxt.preset;
            st_r.ext_ctrl   <= st_nxt.ext_ctrl;
            st_r.flags      <= st_nxt.flags;
            st_r.irq_ctrl   <= st_nxt.irq_ctrl;
            st_r.count      <= st_nxt.count;
            st_r.running    <= st_nxt.running;
            st_r.pin_low    <= st_nxt.pin_low;
            st_r.rel_cnt    <= st_nxt.rel_cnt;
            st_r.evt        <= st_nxt.evt;
            st_r.wreq       <= st_nxt.wreq;
            st_r.pin_oe     <= st_nxt.pin_oe;
        end
    end

    // outputs straight from flip-flops except pin data, tied low; pin only pulls low, other sources share the wire
    assign avs_readdata_o    = st_r.rdata;
    assign avs_waitrequest_o = st_r.wreq;
    assign irq_n_o           = 1'b0;
    assign irq_n_oe_o        = st_r.pin_oe;
    assign timer_event_o     = st_r.evt;

endmodule : pct_timer

//--- testbench/pct_timer_monitor.sv
// checker: bus answer and interrupt pin properties of the periodic timer
`timescale 1ns/1ps
module pct_timer_monitor
    import pct_pkg::*;
#(
    parameter int XTAL_CYC = PCT_XTAL_CYC
) (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        irq_n_o,
    input wire logic        irq_n_oe_o,
    input wire logic        timer_event_o
);
    // two spare ticks cover the phase of the first release tick
    localparam int REL_MAX = (PCT_REL_SLOW_TK + 2) * XTAL_CYC;
    logic [1:0]  ev_age_r;
    logic [31:0] low_cnt_r;

    // age of the last event and length of the current pin low span
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ev_age_r  <= 2'h3;
            low_cnt_r <= 32'h0;
        end else begin
            ev_age_r  <= timer_event_o ? 2'h0 : (ev_age_r == 2'h3 ? 2'h3 : ev_age_r + 2'h1);
            low_cnt_r <= irq_n_oe_o ? 32'h0 : low_cnt_r + 32'h1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_req; $rose(avs_read_i || avs_write_i); endsequence
    sequence s_ack; ##[1:2] !avs_waitrequest_o; endsequence
    property p_answer; s_req |-> s_ack; endproperty
    property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    property p_rd_hi; !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0; endproperty
    property p_rd_hold;
        avs_waitrequest_o && $past(avs_waitrequest_o) |-> $stable(avs_readdata_o);
    endproperty
    property p_od_data; irq_n_o == 1'b0; endproperty
    property p_fall_cause; $fell(irq_n_oe_o) |-> timer_event_o || ev_age_r != 2'h3; endproperty
    property p_release; low_cnt_r <= REL_MAX; endproperty
    property p_ev_gap; timer_event_o |=> !timer_event_o [*8]; endproperty

    a_answer: assert property (p_answer) else $error("request not answered");
    a_wait_one: assert property (p_wait_one) else $error("answer held too long");
    a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved while idle");
    a_od_data: assert property (p_od_data) else $error("pin data not low");
    a_fall_cause: assert property (p_fall_cause) else $error("pin low without event");
    a_release: assert property (p_release) else $error("pin not released");
    a_ev_gap: assert property (p_ev_gap) else $error("events too close");
endmodule : pct_timer_monitor

//--- testbench/pct_host_model.sv
// host model: avalon-mm master issuing one register transfer at a time
`timescale 1ns/1ps
module pct_host_model
    import pct_pkg::*;
(
    input  wire logic        clock_i,
    input  wire pct_av_rsp_t rsp_i,
    output pct_av_req_t      req_o
);
    initial req_o = '0;

    // hold the request until waitrequest is sampled low; idle lines show inverted values
    task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                        output logic [7:0] q);
        q = 8'hXX;
        @(posedge clock_i);
        req_o <= '{{idx, 2'b00}, !wr, wr, {24'h0, d}, 4'hF};
        // no limit here: only the bench watchdog may end a wait
        do begin
            @(posedge clock_i);
        end while (rsp_i.waitrequest !== 1'b0);
        q = rsp_i.readdata[7:0];
        req_o <= '{~req_o.address, 1'b0, 1'b0, ~req_o.writedata, 4'h0};
    endtask : xfer

    // stop the timer and set the source in one write, then write preset and control; start it last
    task automatic setup_timer(input logic [2:0] sel, input logic [15:0] p, input logic [7:0] ctl);
        logic [7:0] q;
        xfer(1'b1, PCT_IDX_EXT_CTRL, {5'h00, sel}, q);
        xfer(1'b1, PCT_IDX_PRESET_LO, p[7:0], q);
        xfer(1'b1, PCT_IDX_PRESET_HI, p[15:8], q);
        xfer(1'b1, PCT_IDX_IRQ_CTRL, ctl, q);
        xfer(1'b1, PCT_IDX_EXT_CTRL, {5'h02, sel}, q);
    endtask : setup_timer

    // the live count is not frozen, so repeat double reads, up to eight times, until two are equal
    task automatic read_count(output logic [15:0] v);
        logic [7:0] lo, hi, lo2, hi2;
        for (int k = 0; k < 8; k++) begin
            xfer(1'b0, PCT_IDX_PRESET_LO, 8'h00, lo);
            xfer(1'b0, PCT_IDX_PRESET_HI, 8'h00, hi);
            xfer(1'b0, PCT_IDX_PRESET_LO, 8'h00, lo2);
            xfer(1'b0, PCT_IDX_PRESET_HI, 8'h00, hi2);
            if ({hi, lo} === {hi2, lo2}) break;
        end
        v = {hi2, lo2};
    endtask : read_count
endmodule : pct_host_model

//--- testbench/tb_periodic_countdown_timer.sv
// testbench: periodic countdown timer driven by a host model
`timescale 1ns/1ps
module tb_periodic_countdown_timer;
    import pct_pkg::*;
    localparam int XC  = 4;
    localparam int T4K = 8 * XC;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        other_n = 1'b1;
    logic        irq_n, irq_oe, tev, wreq, wire_n;
    logic [31:0] rdata;
    pct_av_req_t req;
    int          seed = 32;
    int          bad_count = 0, check_count = 0, cyc = 0, ev_n = 0, ev_last = 0, ev_prev = 0;
    int          n_fall = 0, lowc = 0, low_len = 0, i, e, t0;
    logic [7:0]  q, d;
    logic [15:0] v;

    pct_timer #(.XTAL_CYC(XC), .SEC_PER_MIN(2), .MIN_PER_HOUR(2)) pct_timer_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(req.address),
        .avs_read_i(req.read), .avs_write_i(req.write), .avs_writedata_i(req.writedata),
        .avs_byteenable_i(req.byteenable), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .irq_share_n_i(wire_n), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe), .timer_event_o(tev));
    pct_host_model pct_host_model_inst (.clock_i(clock_i), .rsp_i({rdata, wreq}), .req_o(req));

    // shared open-drain wire; another source pulls it low at random
    assign wire_n = (irq_oe ? 1'b1 : irq_n) & other_n;
    always #5 clock_i = ~clock_i;

    // cycle count, event times and pin low spans
    always @(posedge clock_i) begin
        other_n <= ($random(seed) & 15) != 0;
        cyc <= cyc + 1;
        if (tev === 1'b1) begin
            ev_n <= ev_n + 1;
            ev_prev <= ev_last;
            ev_last <= cyc;
        end
        if (irq_oe === 1'b0) begin
            lowc <= lowc + 1;
            if (lowc == 0) n_fall <= n_fall + 1;
        end else if (lowc != 0) begin
            low_len <= lowc;
            lowc <= 0;
        end
    end

    function automatic int tick(input int s); return (s == 0) ? T4K : 512 * XC;
    endfunction : tick
    function automatic int rel(input int s); return (s == 0) ? 4 * XC : 256 * XC;
    endfunction : rel

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (ex !== got) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask : chk_rng
    task automatic wr(input int a, input logic [7:0] dv);
        logic [7:0] qq;
        pct_host_model_inst.xfer(1'b1, 4'(a), dv, qq);
    endtask : wr
    task automatic rd(input int a, output logic [7:0] qv);
        pct_host_model_inst.xfer(1'b0, 4'(a), 8'h00, qv);
    endtask : rd
    task automatic prog(input int s, input logic [15:0] p, input logic [7:0] ctl);
        pct_host_model_inst.setup_timer(3'(s), p, ctl);
    endtask : prog
    task automatic wait_ev(input int k, input int lim);
        int n, target;
        n = 0;
        target = ev_n + k;
        while (ev_n < target && n < lim) begin
            @(posedge clock_i);
            n++;
        end
        // a limit that runs out is a failure, not a silent return
        if (ev_n < target) begin
            bad_count++;
            $display("CHECK FAILED event wait expected %0d seen %0d", target, ev_n);
        end
    endtask : wait_ev
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // watchdog well beyond the expected run of about 12000 cycles
    initial begin
        #500_000;
        bad_count++;
        finish_test();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        for (i = 11; i < 16; i++) begin
            rd(i, q);
            chk("reset value", 8'h00, q);
        end
        wr(3, 8'hA5);
        rd(3, q);
        chk("unmapped", 8'h00, q);
        for (i = 0; i < 5; i++) begin
            wr(13, 8'(i));
            rd(13, q);
            chk("source select", 32'(i), 32'(q));
        end
        for (i = 11; i < 13; i++) begin
            d = 8'($random(seed));
            wr(i, d);
            rd(i, q);
            chk("storage", d, q);
        end
        prog(0, 16'h0000, 8'h10);
        repeat (300) @(posedge clock_i);
        chk("zero preset", 0, ev_n);
        for (i = 0; i < 2; i++) begin
            v = (i == 0) ? 16'(1 + ($random(seed) & 3)) : 16'h0001;
            prog(i, v, 8'h10);
            wait_ev(3, 4 * 32'(v) * tick(i));
            chk("period", 32'(v) * tick(i), ev_last - ev_prev);
            chk_rng("release", rel(i) - 1, rel(i) + 1, low_len);
            rd(14, q);
            chk("event flag", 8'h10, q);
        end
        prog(0, 16'h0100, 8'h00);
        t0 = cyc;
        repeat (400) @(posedge clock_i);
        pct_host_model_inst.read_count(v);
        e = 256 - (cyc - t0) / T4K;
        chk_rng("live count", e - 2, e + 1, 32'(v));
        wr(13, 8'h00);
        pct_host_model_inst.read_count(v);
        chk("stopped count", 16'h0100, v);
        wr(13, 8'h10);
        pct_host_model_inst.read_count(v);
        chk_rng("restart count", 254, 256, 32'(v));
        prog(1, 16'h0001, 8'h02);
        e = ev_n;
        repeat (2600) @(posedge clock_i);
        chk("halted slow source", e, ev_n);
        prog(0, 16'h0002, 8'h02);
        wait_ev(1, 3 * T4K);
        chk("halted fast source", e + 1, ev_n);
        prog(1, 16'h0001, 8'h10);
        wait_ev(1, 2 * tick(1));
        wr(13, 8'h01);
        chk("pin after stop", 1'b0, irq_oe);
        wr(14, 8'h10);
        rd(14, q);
        chk("flag write one", 8'h10, q);
        wr(14, 8'h00);
        rd(14, q);
        chk("flag clear", 8'h00, q);
        chk("pin after flag clear", 1'b0, irq_oe);
        wr(15, 8'h00);
        repeat (3) @(posedge clock_i);
        #1 chk("pin after enable clear", 1'b1, irq_oe);
        prog(0, 16'h0001, 8'h00);
        e = n_fall;
        wait_ev(3, 4 * T4K);
        chk("enable off", e, n_fall);
        prog(0, 16'h0002, 8'h10);
        wait_ev(1, 3 * T4K);
        wr(15, 8'h14);
        e = ev_n;
        t0 = n_fall;
        repeat (300) @(posedge clock_i);
        chk("paused", e, ev_n);
        wr(15, 8'h10);
        wait_ev(1, 3 * T4K);
        chk("resumed", e + 1, ev_n);
        chk("pin across pause", t0 + 1, n_fall);
        finish_test();
    end
endmodule : tb_periodic_countdown_timer

bind pct_timer pct_timer_monitor #(.XTAL_CYC(XTAL_CYC)) pct_timer_monitor_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o), .timer_event_o(timer_event_o));
